// >>> inc/asc_consts.svh
// How it works
// (RULE1) Hardware reset pulse on the reset pin returns every register to default.
// (RULE2) Host may instead write 81h to general register 0-000h.
// (RULE3) That write resets analog bank converter and master registers; bit self-clears.
// (RULE4) Host writes 00h to 4-001h and 4-002h to clear unused pages.
// (RULE5) Host selects main digital page: 00h to 4-003h, then 68h to 4-004h.
// (RULE6) Writing 01h to 6-0F7h resets all JESD bank pages; bit self-clears.
// (RULE7) Host pulses the channel A commit bit: 01h then 00h to 6-000h.
// (RULE8) Host selects analog master page by writing 80h to 0-011h.
// (RULE9) Host writes 20h to 0-059h to set the always-one bit.
// (RULE10) Host selects JESD digital page: 00h to 4-003h, 69h to 4-004h.
// (RULE11) Host writes 80h to 6-000h on JESD digital page for frame control.
// (RULE12) Out of reset the link uses LMFS 8224 with no decimation.
// (RULE13) Host selects JESD analog page: 00h to 4-003h, 6Ah to 4-004h.
// (RULE14) Host writes 40h then 00h to 6-017h to pulse serializer PLL reset.
// (RULE15) Main digital page settings apply only after the commit pulse.
// (RULE16) Host reselects JESD digital page and writes K to 6-006h.
// (RULE17) Send K28.5 while SYNCB low; after it rises, ILA then converter data.
// (RULE18) Host writes one at a time in order; page selection holds until replaced.
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH

`define ASC_A_GEN_CTRL   16'h0000
`define ASC_A_MASTER_SEL 16'h0011
`define ASC_A_PERF       16'h0059
`define ASC_A_PAGE1      16'h4001
`define ASC_A_PAGE2      16'h4002
`define ASC_A_PAGE3      16'h4003
`define ASC_A_PAGE4      16'h4004
`define ASC_A_DIG_CTRL   16'h6000
`define ASC_A_K_VAL      16'h6006
`define ASC_A_PLL_CTRL   16'h6017
`define ASC_A_BANK_RST   16'h60F7
`define ASC_A_SHADOW0    16'h6001

`define ASC_PG_MAIN      8'h68
`define ASC_PG_JDIG      8'h69
`define ASC_PG_JANA      8'h6A
`define ASC_MASTER_PAGE  8'h80

`define ASC_BIT_SOFT_RST 0
`define ASC_BIT_COMMIT   0
`define ASC_BIT_BANK_RST 0
`define ASC_BIT_PLL_RST  6

`define ASC_RST_BYTE     8'h00
`define ASC_RST_LMFS     16'h8224
`define ASC_ILA_CYCLES   8'h40

`endif

// >>> inc/asc_pkg.sv
package asc_pkg;

    typedef struct packed {
        logic [15:0]     lmfs;
        logic            decim_en;
        logic [7:0]      frame_ctrl;
        logic [7:0]      k_val;
        logic            pll_reset;
        logic [7:0]      perf;
        logic [3:0][7:0] main_regs;
    } asc_cfg_t;

    typedef enum logic [2:0] {
        ASC_LINK_CGS  = 3'b001,
        ASC_LINK_ILA  = 3'b010,
        ASC_LINK_DATA = 3'b100
    } asc_link_state_t;

endpackage : asc_pkg

// >>> hw/asc_startup_cfg.sv
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "asc_consts.svh"

module asc_startup_cfg
    import asc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    input  wire logic        hw_reset_pin,
    input  wire logic        syncb_pin,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    output asc_cfg_t         link_cfg,
    output asc_link_state_t  link_state
);

    function automatic logic on_page(input logic [7:0] sel3, input logic [7:0] sel4,
                                     input logic [7:0] want);
        on_page = (sel3 == 8'h00) && (sel4 == want);
    endfunction : on_page

    // Pin synchronisers; first stage feeds only the second
    logic hw_meta;
    logic hw_sync;
    logic sy_meta;
    logic sy_sync;

    logic [7:0]      gen_ctrl;
    logic [7:0]      master_sel;
    logic [7:0]      perf;
    logic [7:0]      page1;
    logic [7:0]      page2;
    logic [7:0]      page3;
    logic [7:0]      page4;
    logic [7:0]      dig_ctrl;
    logic [7:0]      frame_ctrl;
    logic [7:0]      k_val;
    logic [7:0]      pll_ctrl;
    logic [3:0][7:0] shadow;
    logic [7:0]      ila_cnt;

    wire pg_main = on_page(page3, page4, `ASC_PG_MAIN);
    wire pg_jdig = on_page(page3, page4, `ASC_PG_JDIG);
    wire pg_jana = on_page(page3, page4, `ASC_PG_JANA);
    wire pg_mstr = (master_sel == `ASC_MASTER_PAGE);

    wire wr_gen    = reg_wr && (reg_addr == `ASC_A_GEN_CTRL);
    wire soft_rst  = wr_gen && reg_wdata[`ASC_BIT_SOFT_RST];
    wire wr_msel   = reg_wr && (reg_addr == `ASC_A_MASTER_SEL);
    wire wr_perf   = reg_wr && pg_mstr && (reg_addr == `ASC_A_PERF);
    wire wr_pg1    = reg_wr && (reg_addr == `ASC_A_PAGE1);
    wire wr_pg2    = reg_wr && (reg_addr == `ASC_A_PAGE2);
    wire wr_pg3    = reg_wr && (reg_addr == `ASC_A_PAGE3);
    wire wr_pg4    = reg_wr && (reg_addr == `ASC_A_PAGE4);
    wire wr_dig    = reg_wr && pg_main && (reg_addr == `ASC_A_DIG_CTRL);
    wire bank_rst  = reg_wr && pg_main && (reg_addr == `ASC_A_BANK_RST)
                     && reg_wdata[`ASC_BIT_BANK_RST];
    wire wr_frame  = reg_wr && pg_jdig && (reg_addr == `ASC_A_DIG_CTRL);
    wire wr_k      = reg_wr && pg_jdig && (reg_addr == `ASC_A_K_VAL);
    wire wr_pll    = reg_wr && pg_jana && (reg_addr == `ASC_A_PLL_CTRL);
    // Commit takes effect on the falling half of the pulse
    wire commit_fall = wr_dig && dig_ctrl[`ASC_BIT_COMMIT]
                       && !reg_wdata[`ASC_BIT_COMMIT];
    wire jesd_clear  = hw_sync || bank_rst;

    logic [3:0] wr_shadow;
    logic [3:0] rd_shadow;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_shadow
            wire [15:0] sh_addr = `ASC_A_SHADOW0 + 16'(gi);
            assign rd_shadow[gi] = pg_main && (reg_addr == sh_addr);
            assign wr_shadow[gi] = reg_wr && rd_shadow[gi];
            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    shadow[gi] <= `ASC_RST_BYTE;
                end else if (clk_en) begin
                    if (jesd_clear) begin
                        shadow[gi] <= `ASC_RST_BYTE;   // [RULE1] [RULE6]
                    end else if (wr_shadow[gi]) begin
                        shadow[gi] <= reg_wdata;
                    end
                end
            end
        end
    endgenerate

    // Self-clearing bits are never stored, so they read back as zero
    wire [7:0] rd_mux =
        (reg_addr == `ASC_A_GEN_CTRL)          ? gen_ctrl :
        (reg_addr == `ASC_A_MASTER_SEL)        ? master_sel :
        (pg_mstr && reg_addr == `ASC_A_PERF)   ? perf :
        (reg_addr == `ASC_A_PAGE1)             ? page1 :
        (reg_addr == `ASC_A_PAGE2)             ? page2 :
        (reg_addr == `ASC_A_PAGE3)             ? page3 :
        (reg_addr == `ASC_A_PAGE4)             ? page4 :
        (pg_main && reg_addr == `ASC_A_DIG_CTRL) ? dig_ctrl :
        rd_shadow[0]                           ? shadow[0] :
        rd_shadow[1]                           ? shadow[1] :
        rd_shadow[2]                           ? shadow[2] :
        rd_shadow[3]                           ? shadow[3] :
        (pg_jdig && reg_addr == `ASC_A_DIG_CTRL) ? frame_ctrl :
        (pg_jdig && reg_addr == `ASC_A_K_VAL)  ? k_val :
        (pg_jana && reg_addr == `ASC_A_PLL_CTRL) ? pll_ctrl :
        8'h00;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hw_meta <= 1'b0;
            hw_sync <= 1'b0;
            sy_meta <= 1'b0;
            sy_sync <= 1'b0;
        end else if (clk_en) begin
            hw_meta <= hw_reset_pin;
            hw_sync <= hw_meta;
            sy_meta <= syncb_pin;
            sy_sync <= sy_meta;
        end
    end

    // Analog bank and page selects
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            gen_ctrl   <= `ASC_RST_BYTE;
            master_sel <= `ASC_RST_BYTE;
            perf       <= `ASC_RST_BYTE;
            page1      <= `ASC_RST_BYTE;
            page2      <= `ASC_RST_BYTE;
            page3      <= `ASC_RST_BYTE;
            page4      <= `ASC_RST_BYTE;
        end else if (clk_en) begin
            if (hw_sync) begin                           // [RULE1]
                gen_ctrl   <= `ASC_RST_BYTE;
                master_sel <= `ASC_RST_BYTE;
                perf       <= `ASC_RST_BYTE;
                page1      <= `ASC_RST_BYTE;
                page2      <= `ASC_RST_BYTE;
                page3      <= `ASC_RST_BYTE;
                page4      <= `ASC_RST_BYTE;
            end else if (soft_rst) begin                 // [RULE3]
                gen_ctrl   <= {reg_wdata[7:1], 1'b0};
                master_sel <= `ASC_RST_BYTE;
                perf       <= `ASC_RST_BYTE;
            end else begin
                if (wr_gen)  gen_ctrl   <= {reg_wdata[7:1], 1'b0};
                if (wr_msel) master_sel <= reg_wdata;
                if (wr_perf) perf       <= reg_wdata;
                if (wr_pg1)  page1      <= reg_wdata;
                if (wr_pg2)  page2      <= reg_wdata;
                if (wr_pg3)  page3      <= reg_wdata;
                if (wr_pg4)  page4      <= reg_wdata;
            end
        end
    end

    // JESD bank pages; page selects survive the bank reset so the host keeps its place
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dig_ctrl   <= `ASC_RST_BYTE;
            frame_ctrl <= `ASC_RST_BYTE;
            k_val      <= `ASC_RST_BYTE;
            pll_ctrl   <= `ASC_RST_BYTE;
        end else if (clk_en) begin
            if (jesd_clear) begin                        // [RULE1] [RULE6]
                dig_ctrl   <= `ASC_RST_BYTE;
                frame_ctrl <= `ASC_RST_BYTE;
                k_val      <= `ASC_RST_BYTE;
                pll_ctrl   <= `ASC_RST_BYTE;
            end else begin
                if (wr_dig)   dig_ctrl   <= reg_wdata;
                if (wr_frame) frame_ctrl <= reg_wdata;
                if (wr_k)     k_val      <= reg_wdata;
                if (wr_pll)   pll_ctrl   <= reg_wdata;
            end
        end
    end

    // Active link settings; main page copies move only on commit or on bank/pin clear
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            link_cfg.lmfs       <= `ASC_RST_LMFS;        // [RULE12]
            link_cfg.decim_en   <= 1'b0;
            link_cfg.frame_ctrl <= `ASC_RST_BYTE;
            link_cfg.k_val      <= `ASC_RST_BYTE;
            link_cfg.pll_reset  <= 1'b0;
            link_cfg.perf       <= `ASC_RST_BYTE;
            link_cfg.main_regs  <= '0;
        end else if (clk_en) begin
            link_cfg.lmfs       <= `ASC_RST_LMFS;        // [RULE12]
            link_cfg.decim_en   <= 1'b0;
            link_cfg.frame_ctrl <= frame_ctrl;
            link_cfg.k_val      <= k_val;
            link_cfg.pll_reset  <= pll_ctrl[`ASC_BIT_PLL_RST];
            link_cfg.perf       <= perf;
            if (jesd_clear) begin
                link_cfg.main_regs <= '0;                // [RULE6]
            end else if (commit_fall) begin
                link_cfg.main_regs <= shadow;            // [RULE15]
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // Lane framing: code groups, alignment sequence, then samples
    asc_link_state_t next_link_state;
    wire ila_done = (ila_cnt == `ASC_ILA_CYCLES - 8'h01);
    always_comb begin
        next_link_state = link_state;
        case (link_state)
            ASC_LINK_CGS:  if (sy_sync) next_link_state = ASC_LINK_ILA;
            ASC_LINK_ILA:  if (ila_done) next_link_state = ASC_LINK_DATA;
            ASC_LINK_DATA: next_link_state = ASC_LINK_DATA;
            default:       next_link_state = ASC_LINK_CGS;
        endcase
        if (!sy_sync || jesd_clear) begin
            next_link_state = ASC_LINK_CGS;              // [RULE17]
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            link_state <= ASC_LINK_CGS;
            ila_cnt    <= 8'h00;
        end else if (clk_en) begin
            link_state <= next_link_state;               // [RULE17]
            ila_cnt    <= (link_state == ASC_LINK_ILA) ? ila_cnt + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_hw_reset_clear: assert property (clk_en && hw_sync |=>    // [RULE1]
        link_cfg.main_regs == '0 && perf == 8'h00 && k_val == 8'h00)
        else $error("hardware reset left state");
    a_soft_reset_analog: assert property (clk_en && soft_rst && !hw_sync |=> // [RULE3]
        perf == 8'h00 && master_sel == 8'h00 && gen_ctrl[0] == 1'b0)
        else $error("soft reset missed analog bank");
    a_bank_reset_pages: assert property (clk_en && bank_rst |=>  // [RULE6]
        shadow == '0 && dig_ctrl == 8'h00 && frame_ctrl == 8'h00 && pll_ctrl == 8'h00)
        else $error("bank reset missed pages");
    a_commit_hold_cfg: assert property (clk_en && !commit_fall && !jesd_clear |=> // [RULE15]
        $stable(link_cfg.main_regs))
        else $error("main page applied without commit");
    a_commit_apply_cfg: assert property (clk_en && commit_fall && !jesd_clear |=> // [RULE15]
        link_cfg.main_regs == $past(shadow))
        else $error("commit did not apply settings");
    a_lmfs_default: assert property (clk_en |=>                // [RULE12]
        link_cfg.lmfs == 16'h8224 && !link_cfg.decim_en)
        else $error("link not at default format");
    a_cgs_sync_low: assert property (clk_en && !sy_sync |=> link_state == ASC_LINK_CGS) // [RULE17]
        else $error("not sending code groups");
    a_ila_before_data: assert property ($rose(link_state == ASC_LINK_DATA) |-> // [RULE17]
        $past(link_state) == ASC_LINK_ILA && $past(ila_cnt) == 8'h3F)
        else $error("data without alignment phase");
    a_read_one_cycle: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    a_pin_reset_link: assert property (clk_en && hw_sync |=>    // [RULE1]
        link_state == ASC_LINK_CGS && page4 == `ASC_RST_BYTE)
        else $error("hardware reset left link running");
    a_pin_reset_pages: assert property (clk_en && hw_sync |=>   // [RULE1]
        shadow == '0 && dig_ctrl == 8'h00 && frame_ctrl == 8'h00 && pll_ctrl == 8'h00)
        else $error("hardware reset missed bank pages");
    a_pin_reset_analog: assert property (clk_en && hw_sync |=>  // [RULE1]
        gen_ctrl == 8'h00 && master_sel == 8'h00 && page1 == 8'h00 && page3 == 8'h00)
        else $error("hardware reset missed analog bank");
    a_soft_self_clear: assert property (clk_en && wr_gen && !hw_sync |=> // [RULE3]
        gen_ctrl[`ASC_BIT_SOFT_RST] == 1'b0)
        else $error("soft reset bit stayed set");
    a_soft_keeps_pages: assert property (clk_en && soft_rst && !hw_sync |=> // [RULE3]
        $stable(page4) && $stable(dig_ctrl) && $stable(k_val))
        else $error("soft reset touched bank pages");
    a_bank_reset_link: assert property (clk_en && bank_rst |=>  // [RULE6]
        link_state == ASC_LINK_CGS && k_val == 8'h00)
        else $error("bank reset left link running");
    a_bank_keeps_page: assert property (clk_en && bank_rst && !hw_sync |=> // [RULE6]
        $stable(page3) && $stable(page4))
        else $error("bank reset lost page select");
    a_ila_after_sync: assert property (clk_en && sy_sync && !jesd_clear && // [RULE17]
        link_state == ASC_LINK_CGS |=> link_state == ASC_LINK_ILA)
        else $error("no alignment after sync");
    a_ila_counting: assert property (clk_en && sy_sync && !jesd_clear && // [RULE17]
        !ila_done && link_state == ASC_LINK_ILA |=> link_state == ASC_LINK_ILA)
        else $error("alignment phase cut short");
    a_data_holds: assert property (clk_en && sy_sync && !jesd_clear && // [RULE17]
        link_state == ASC_LINK_DATA |=> link_state == ASC_LINK_DATA)
        else $error("data phase dropped while in sync");
    a_frozen_state: assert property (!clk_en |=>
        $stable(link_state) && $stable(link_cfg) && $stable(reg_rdata))
        else $error("state moved while clock disabled");

endmodule : asc_startup_cfg

// >>> verif/asc_host_model.sv
`timescale 1ns/1ns
`include "asc_consts.svh"

module asc_host_model (
    input  wire logic        ref_clk,
    output logic      [15:0] reg_addr,
    output logic      [7:0]  reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [7:0]  reg_rdata
);
    initial begin
        reg_addr  = 16'h0000;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // One access at a time; idle lines show the inverse so stale values never pass
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata;
    endtask : rd

    // Page pair written low half first
    task automatic sel_page(input logic [7:0] p);
        wr(`ASC_A_PAGE3, 8'h00);
        wr(`ASC_A_PAGE4, p);
    endtask : sel_page

    task automatic commit();
        wr(`ASC_A_DIG_CTRL, 8'h01);
        wr(`ASC_A_DIG_CTRL, 8'h00);
    endtask : commit
endmodule : asc_host_model

// >>> verif/tb.sv
`timescale 1ns/1ns
`include "asc_consts.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
    $display("Error at %0t: got %h, expected %h", $time, (a), (e)); end end

module tb
    import asc_pkg::*;
;
    logic            ref_clk, reset_n, clk_en, hw_reset_pin, syncb_pin;
    logic [15:0]     reg_addr;
    logic [7:0]      reg_wdata, reg_rdata, rv;
    logic            reg_wr, reg_rd;
    asc_cfg_t        link_cfg;
    asc_link_state_t link_state;
    int              n_mismatch = 0;
    int              checks_done = 0;

    asc_startup_cfg uut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
        .hw_reset_pin(hw_reset_pin), .syncb_pin(syncb_pin), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .link_cfg(link_cfg), .link_state(link_state));

    asc_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    task automatic rc(input logic [15:0] a, input logic [7:0] e);
        host.rd(a, rv);
        `CHK(rv, e)
    endtask : rc

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    initial begin
        #50000;
        n_mismatch++;
        close_out();
    end

    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        hw_reset_pin = 1'b0;
        syncb_pin = 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        #1;
        `CHK(link_cfg.lmfs, `ASC_RST_LMFS) // Default link shape
        `CHK(link_cfg.decim_en, 1'b0) // No decimation
        `CHK(link_state, ASC_LINK_CGS) // Sync characters first
        host.wr(`ASC_A_PERF, 8'h20); // Master page not yet selected
        rc(`ASC_A_PERF, 8'h00); // Off-page write dropped
        host.wr(`ASC_A_MASTER_SEL, `ASC_MASTER_PAGE); // Master page
        host.wr(`ASC_A_PERF, 8'h20); // Always-one bit
        rc(`ASC_A_PERF, 8'h20); // Stored
        `CHK(link_cfg.perf, 8'h20) // Reaches config
        host.wr(`ASC_A_GEN_CTRL, 8'h81); // Soft reset
        rc(`ASC_A_GEN_CTRL, 8'h80); // Bit 0 cleared itself
        rc(`ASC_A_MASTER_SEL, 8'h00); // Master select cleared
        host.wr(`ASC_A_MASTER_SEL, `ASC_MASTER_PAGE); // Master page again
        rc(`ASC_A_PERF, 8'h00); // Analog bank cleared
        `CHK(link_cfg.perf, 8'h00) // Cleared in config too
        host.wr(`ASC_A_PAGE1, 8'hA5); // Stale content
        host.wr(`ASC_A_PAGE2, 8'hA5); // Stale content
        rc(`ASC_A_PAGE1, 8'hA5); // Plain storage
        host.wr(`ASC_A_PAGE1, 8'h00); // Scrub unused page
        host.wr(`ASC_A_PAGE2, 8'h00); // Scrub unused page
        rc(`ASC_A_PAGE1, 8'h00); // Scrubbed
        rc(`ASC_A_PAGE2, 8'h00); // Scrubbed
        host.sel_page(`ASC_PG_MAIN); // Main digital page
        host.wr(`ASC_A_SHADOW0, 8'h5A); // Staged only
        cyc(3);
        `CHK(link_cfg.main_regs[0], 8'h00) // Not yet in force
        host.commit(); // Commit pulse
        cyc(3);
        `CHK(link_cfg.main_regs[0], 8'h5A) // In force after pulse
        rc(`ASC_A_DIG_CTRL, 8'h00); // Pulse left low
        host.wr(`ASC_A_BANK_RST, 8'h01); // Bank reset
        rc(`ASC_A_BANK_RST, 8'h00); // Cleared itself
        rc(`ASC_A_SHADOW0, 8'h00); // Page contents gone
        `CHK(link_cfg.main_regs[0], 8'h00) // Committed copy gone
        rc(`ASC_A_PAGE4, `ASC_PG_MAIN); // Page select survives
        host.sel_page(`ASC_PG_JDIG); // JESD digital page
        host.wr(`ASC_A_DIG_CTRL, 8'h80); // Frame-count control
        host.wr(`ASC_A_K_VAL, 8'h1F); // Frame parameter
        cyc(2);
        `CHK(link_cfg.frame_ctrl, 8'h80) // Control in force
        `CHK(link_cfg.k_val, 8'h1F) // Frame parameter in force
        host.sel_page(`ASC_PG_JANA); // JESD analog page
        host.wr(`ASC_A_K_VAL, 8'h33); // Wrong page for this offset
        host.wr(`ASC_A_PLL_CTRL, 8'h40); // PLL held in reset
        cyc(2);
        `CHK(link_cfg.pll_reset, 1'b1) // Reset applied
        `CHK(link_cfg.k_val, 8'h1F) // Wrong-page write ignored
        host.wr(`ASC_A_PLL_CTRL, 8'h00); // Release
        cyc(2);
        `CHK(link_cfg.pll_reset, 1'b0) // Released
        rc(16'h0123, 8'h00); // Unmapped offset reads zero
        @(posedge ref_clk);
        clk_en <= 1'b0;
        host.wr(`ASC_A_PAGE1, 8'h77); // Frozen, not taken
        clk_en <= 1'b1;
        rc(`ASC_A_PAGE1, 8'h00); // Old content kept
        @(posedge ref_clk);
        syncb_pin <= 1'b1;
        cyc(10);
        `CHK(link_state, ASC_LINK_ILA) // Alignment after sync rises
        cyc(60);
        `CHK(link_state, ASC_LINK_DATA) // Then converter data
        @(posedge ref_clk);
        syncb_pin <= 1'b0;
        cyc(5);
        `CHK(link_state, ASC_LINK_CGS) // Back to sync characters
        @(posedge ref_clk);
        hw_reset_pin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        hw_reset_pin <= 1'b0;
        cyc(5);
        `CHK(link_cfg.k_val, 8'h00) // Pin pulse clears registers
        `CHK(link_cfg.frame_ctrl, 8'h00) // Pin pulse clears registers
        rc(`ASC_A_PAGE4, 8'h00); // Page select back to default
        `CHK(link_cfg.lmfs, `ASC_RST_LMFS) // Default link shape
        close_out();
    end
endmodule : tb
